// >>> include/rmw_pkg.sv
// Purpose: Shared constants and types for the locked byte cycle sequencer
// Assumes: Single 25 MHz core clock, one state per half clock collapsed to one clock
// Notes:   Bus state numbers count sequencer states, not clock edges
package rmw_pkg;
  localparam int CLK_NS          = 40;
  localparam int ADDR_W          = 32;
  localparam int FC_W            = 3;
  localparam int DATA_W          = 16;
  // Grant drop window after acknowledge, in tenths of a clock
  localparam int GNT_DROP_MIN_T  = 15;
  localparam int GNT_DROP_MAX_T  = 35;
  localparam int GNT_DROP_CYC    = (GNT_DROP_MIN_T + 9) / 10;
  localparam logic [3:0] MODIFY_HOLD = 4'h4;
  localparam logic [3:0] WERR_HOLD   = 4'h4;
  localparam logic [3:0] RERR_DS_GAP = 4'h2;
  localparam logic [3:0] RERR_AS_GAP = 4'h2;
  localparam logic       LOCK_IDLE   = 1'b1;

  typedef enum logic [1:0] {
    RMW_ARB_IDLE,
    RMW_ARB_GRANT,
    RMW_ARB_OWNED,
    RMW_ARB_HOLD
  } rmw_arb_type;
endpackage

// >>> include/rmw_arb_if.sv
// Purpose: Carrier between sequencer and arbiter
// Assumes: Both ends on clk_sys
// Notes:   Plain levels only
`timescale 1ns/100ps
interface rmw_arb_if;
  logic as_active;
  logic committed;
  logic float_req;
  modport seq (output as_active, output committed, input float_req);
  modport arb (input as_active, input committed, output float_req);
endinterface

// >>> rtl/rmw_arbiter.sv
// Purpose: Bus request, grant and acknowledge handling
// Assumes: Request and acknowledge arrive asynchronously
// Notes:   Two-wire use ties acknowledge negated outside
`timescale 1ns/100ps
module rmw_arbiter
  import rmw_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic bus_request_n,
  input  wire logic grant_ack_n,
  output logic      bus_grant_n,
  rmw_arb_if.arb    arb
);
  logic [1:0]  req_sync_q;
  logic [1:0]  ack_sync_q;
  rmw_arb_type st_q;
  logic [1:0]  drop_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req_sync_q <= 2'b00;
      ack_sync_q <= 2'b00;
    end else begin
      req_sync_q <= {req_sync_q[0], ~bus_request_n};
      ack_sync_q <= {ack_sync_q[0], ~grant_ack_n};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q        <= RMW_ARB_IDLE;
      bus_grant_n <= 1'b1;
      drop_q      <= 2'b00;
    end else begin
      case (st_q)
        RMW_ARB_IDLE: begin
          if (req_sync_q[1] && !(arb.committed && !arb.as_active)) begin
            st_q        <= RMW_ARB_GRANT;
            bus_grant_n <= 1'b0;
          end
        end
        RMW_ARB_GRANT: begin
          if (ack_sync_q[1]) begin
            // drop at once; sync already spends two clocks
            st_q        <= RMW_ARB_OWNED;
            bus_grant_n <= 1'b1;
            drop_q      <= 2'(GNT_DROP_CYC);
          end else if (!req_sync_q[1]) begin
            st_q        <= RMW_ARB_IDLE;
            bus_grant_n <= 1'b1;
          end
        end
        RMW_ARB_OWNED: begin
          if (drop_q <= 2'd1) begin
            st_q <= RMW_ARB_HOLD;
          end else begin
            drop_q <= drop_q - 2'd1;
          end
        end
        RMW_ARB_HOLD: begin
          // regrant with no own cycle between
          if (req_sync_q[1]) begin
            bus_grant_n <= 1'b0;
            st_q        <= RMW_ARB_GRANT;
          end else if (!ack_sync_q[1]) begin
            st_q <= RMW_ARB_IDLE;
          end
        end
        default: st_q <= RMW_ARB_IDLE;
      endcase
    end
  end

  assign arb.float_req = (st_q != RMW_ARB_IDLE && !bus_grant_n) || ack_sync_q[1];

  a_grant_drop_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == RMW_ARB_GRANT && ack_sync_q[1]) |-> ##[1:3] bus_grant_n)
    else $error("grant not negated after acknowledge");
  a_grant_sync_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(bus_grant_n) |-> $past(req_sync_q[1]))
    else $error("grant without synchronized request");
endmodule

// >>> rtl/rmw_sequencer.sv
// Behaviour
// - Address strobe stays asserted across read and write portions.
// - Exactly one byte strobe with the data strobe, never both.
// - First state drives code, address, both write lines high, start high.
// - Second state drops start indicator and locked indicator.
// - Third state asserts address, byte and data strobes.
// - Read waits whole clocks until acknowledge or error.
// - Acknowledged read latches data and drops data strobes only.
// - Outputs hold four states while the byte is modified.
// - Write drops early write line, then write line, then drives data.
// - Write asserts strobes then waits for acknowledge or error.
// - Acknowledged write drops strobes, floats data, raises write lines.
// - Acknowledge with error on read aborts, address strobe dropped later.
// - Error alone on read drops data strobes, then address strobe.
// - Error alone on write holds four states then drops all strobes.
// - Locked indicator returns high after address strobe negation.
// - Device yields after current cycle; withdrawn request keeps bus.
// - Grant follows synchronized request, delayed while cycle committed.
// - Grant drops 1.5 to 3.5 clocks after acknowledge, regrants.
// - Request and acknowledge synchronized before use.
// - Outputs float when another master owns the idle bus.
// - Error in locked cycle is never retried, halt ignored.
// - Address bit zero low uses upper lane, high the lower lane.
//
// Purpose: Locked byte read-modify-write sequencer with bus arbitration
// Assumes: Inputs other than request and acknowledge synchronous to clk_sys, one state per clock
// Notes:   Modify step ORs the fetched byte with the external modify_mask
`timescale 1ns/100ps
module rmw_sequencer
  import rmw_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                start,
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [FC_W-1:0]     fc_in,
  input  wire logic [7:0]          modify_mask,
  input  wire logic                transfer_ack_n,
  input  wire logic                bus_error_n,
  input  wire logic                halt_in_n,
  input  wire logic                bus_request_n,
  input  wire logic                grant_ack_n,
  input  wire logic [DATA_W-1:0]   data_in,
  output logic [DATA_W-1:0]        data_out,
  output logic                     data_oe,
  output logic [ADDR_W-1:0]        address,
  output logic                     address_oe,
  output logic [FC_W-1:0]          function_code,
  output logic                     ctrl_oe,
  output logic                     addr_strobe_n,
  output logic                     upper_byte_strobe_n,
  output logic                     lower_byte_strobe_n,
  output logic                     data_strobe_n,
  output logic                     read_write_n,
  output logic                     early_read_write_n,
  output logic                     cycle_start_indicator,
  output logic                     locked_cycle_n,
  output logic                     bus_grant_n,
  output logic                     done,
  output logic                     bus_fault,
  output logic [7:0]               read_byte
);
  typedef enum logic [3:0] {
    SQ_IDLE, SQ_S1, SQ_S2, SQ_RWAIT, SQ_RDONE, SQ_RERR, SQ_MOD,
    SQ_W13, SQ_W14, SQ_W15, SQ_W16, SQ_WDONE, SQ_WERR, SQ_END
  } rmw_seq_type;

  rmw_seq_type st_q;
  logic [3:0]  cnt_q;
  logic        ack_err_q;
  logic        upper_q;
  logic        ack;
  logic        err;

  rmw_arb_if   arb_c ();

  assign ack = ~transfer_ack_n;
  assign err = ~bus_error_n;

  assign arb_c.committed = (st_q == SQ_S1);
  assign arb_c.as_active = ~addr_strobe_n;

  rmw_arbiter u_arb (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .bus_request_n (bus_request_n),
    .grant_ack_n   (grant_ack_n),
    .bus_grant_n   (bus_grant_n),
    .arb           (arb_c.arb)
  );

  // Main sequence
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q                  <= SQ_IDLE;
      cnt_q                 <= 4'h0;
      ack_err_q             <= 1'b0;
      upper_q               <= 1'b0;
      addr_strobe_n         <= 1'b1;
      upper_byte_strobe_n   <= 1'b1;
      lower_byte_strobe_n   <= 1'b1;
      data_strobe_n         <= 1'b1;
      read_write_n          <= 1'b1;
      early_read_write_n    <= 1'b1;
      cycle_start_indicator <= 1'b1;
      locked_cycle_n        <= LOCK_IDLE;
      data_oe               <= 1'b0;
      data_out              <= '0;
      address               <= '0;
      function_code         <= '0;
      done                  <= 1'b0;
      bus_fault             <= 1'b0;
      read_byte             <= 8'h00;
    end else begin
      done <= 1'b0;
      case (st_q)
        SQ_IDLE: begin
          read_write_n          <= 1'b1;
          early_read_write_n    <= 1'b1;
          cycle_start_indicator <= 1'b1;
          locked_cycle_n        <= LOCK_IDLE;
          // no new cycle while grant is out
          if (start && bus_grant_n && !arb_c.float_req) begin
            address       <= addr_in;
            function_code <= fc_in;
            upper_q       <= ~addr_in[0];
            bus_fault     <= 1'b0;
            st_q          <= SQ_S1;
          end
        end
        SQ_S1: begin
          cycle_start_indicator <= 1'b0;
          locked_cycle_n        <= 1'b0;
          st_q                  <= SQ_S2;
        end
        SQ_S2: begin
          addr_strobe_n       <= 1'b0;
          data_strobe_n       <= 1'b0;
          upper_byte_strobe_n <= ~upper_q;
          lower_byte_strobe_n <= upper_q;
          st_q                <= SQ_RWAIT;
        end
        SQ_RWAIT: begin
          if (err) begin
            ack_err_q <= ack;
            cnt_q     <= ack ? 4'h0 : RERR_DS_GAP;
            st_q      <= SQ_RERR;
          end else if (ack) begin
            st_q <= SQ_RDONE;
          end
        end
        SQ_RDONE: begin
          // latch, drop data strobes, keep address strobe
          read_byte           <= upper_q ? data_in[15:8] : data_in[7:0];
          data_strobe_n       <= 1'b1;
          upper_byte_strobe_n <= 1'b1;
          lower_byte_strobe_n <= 1'b1;
          cnt_q               <= MODIFY_HOLD;
          st_q                <= SQ_MOD;
        end
        SQ_MOD: begin
          if (cnt_q <= 4'h1) begin
            st_q <= SQ_W13;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        SQ_W13: begin
          early_read_write_n <= 1'b0;
          st_q               <= SQ_W14;
        end
        SQ_W14: begin
          read_write_n <= 1'b0;
          st_q         <= SQ_W15;
        end
        SQ_W15: begin
          data_out <= {read_byte | modify_mask, read_byte | modify_mask};
          data_oe  <= 1'b1;
          st_q     <= SQ_W16;
        end
        SQ_W16: begin
          data_strobe_n       <= 1'b0;
          upper_byte_strobe_n <= ~upper_q;
          lower_byte_strobe_n <= upper_q;
          if (!data_strobe_n && ack) begin
            bus_fault <= err;
            st_q      <= SQ_WDONE;
          end else if (!data_strobe_n && err) begin
            cnt_q <= WERR_HOLD;
            st_q  <= SQ_WERR;
          end
        end
        SQ_WDONE: begin
          addr_strobe_n       <= 1'b1;
          data_strobe_n       <= 1'b1;
          upper_byte_strobe_n <= 1'b1;
          lower_byte_strobe_n <= 1'b1;
          st_q                <= SQ_END;
        end
        SQ_WERR: begin
          if (cnt_q <= 4'h1) begin
            addr_strobe_n       <= 1'b1;
            data_strobe_n       <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            lower_byte_strobe_n <= 1'b1;
            bus_fault           <= 1'b1;
            st_q                <= SQ_END;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        SQ_RERR: begin
          // data strobes drop, then address strobe, no write
          if (cnt_q == 4'h0) begin
            data_strobe_n       <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            lower_byte_strobe_n <= 1'b1;
            cnt_q               <= ack_err_q ? (RERR_AS_GAP + 4'h2) : RERR_AS_GAP;
            st_q                <= SQ_WERR;
            bus_fault           <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        SQ_END: begin
          data_oe            <= 1'b0;
          read_write_n       <= 1'b1;
          early_read_write_n <= 1'b1;
          done               <= 1'b1;
          st_q               <= SQ_IDLE;
        end
        default: st_q <= SQ_IDLE;
      endcase
    end
  end

  // float when another master holds bus
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      address_oe <= 1'b1;
      ctrl_oe    <= 1'b1;
    end else begin
      address_oe <= !(arb_c.float_req && addr_strobe_n && st_q == SQ_IDLE);
      ctrl_oe    <= !(arb_c.float_req && addr_strobe_n && st_q == SQ_IDLE);
    end
  end

  // strobe held through modify and write
  a_as_locked: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q inside {SQ_MOD, SQ_W13, SQ_W14, SQ_W15, SQ_W16}) |-> !addr_strobe_n)
    else $error("address strobe dropped inside locked cycle");
  a_one_lane: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(!upper_byte_strobe_n && !lower_byte_strobe_n))
    else $error("both byte strobes asserted");
  a_lock_low_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_S1) |=> (!cycle_start_indicator && !locked_cycle_n))
    else $error("start or lock not low in second state");
  a_strobes_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_S2) |=> (!addr_strobe_n && !data_strobe_n))
    else $error("strobes not asserted in third state");
  a_modify_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_RDONE) |=> (st_q == SQ_MOD) [*4] ##1 (st_q == SQ_W13))
    else $error("modify hold not four states");
  a_write_order: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_W13) |=> !early_read_write_n && read_write_n ##1 !read_write_n ##1 data_oe)
    else $error("write line order wrong");
  a_write_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_WDONE) |=> addr_strobe_n ##1 (read_write_n && !data_oe))
    else $error("write end sequence wrong");
  a_lane_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_S2) |=> (upper_byte_strobe_n == address[0]))
    else $error("wrong byte lane for address bit zero");
  a_idle_levels: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_S1) |-> (read_write_n && early_read_write_n && cycle_start_indicator))
    else $error("read levels or start indicator wrong in first state");
  a_wait_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_RWAIT && !ack && !err) |=> (st_q == SQ_RWAIT && !data_strobe_n && !addr_strobe_n))
    else $error("read wait left without termination");
  a_read_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_RDONE) |=> (data_strobe_n && upper_byte_strobe_n && lower_byte_strobe_n && !addr_strobe_n))
    else $error("read end strobes wrong");
  a_lock_return: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(addr_strobe_n) |-> ##[1:4] locked_cycle_n)
    else $error("locked indicator not returned high");
  a_no_retry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (st_q == SQ_RWAIT && err && !halt_in_n) |=> (st_q == SQ_RERR))
    else $error("bus error with halt not handled as error");
endmodule

// >>> bench/rmw_slave_model.sv
// Purpose: Slave memory that ends locked byte cycles
// Assumes: Terminations are sampled by the sequencer on clk_sys
// Notes:   Mode 0 ack, 1 ack with error, 2 error alone
`timescale 1ns/100ps
module rmw_slave_model
  import rmw_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              data_strobe_n,
  input  wire logic              read_write_n,
  input  wire logic [1:0]        rd_mode,
  input  wire logic [1:0]        wr_mode,
  input  wire logic [3:0]        wait_cyc,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic                   transfer_ack_n,
  output logic                   bus_error_n,
  output logic [DATA_W-1:0]      data_in
);
  logic [3:0] cnt_q;
  logic       hit;
  logic [1:0] mode;

  assign mode = read_write_n ? rd_mode : wr_mode;
  assign hit  = !data_strobe_n && cnt_q >= wait_cyc;
  assign transfer_ack_n = !(hit && mode != 2'h2);
  assign bus_error_n    = !(hit && mode != 2'h0);

  // Whole clocks of wait before terminating
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else if (data_strobe_n) begin
      cnt_q <= 4'h0;
    end else if (!hit) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Data only while strobed; moving pattern so stale data never passes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_in <= '0;
    end else if (!data_strobe_n && read_write_n) begin
      data_in <= rd_data;
    end else begin
      data_in <= ~data_in;
    end
  end
endmodule

// >>> bench/test_rmw_bus_cycle_and_arbitration.sv
// Purpose: Self-checking bench for the locked byte sequencer
// Assumes: Slave model answers every strobed cycle
// Notes:   Timing judged as gaps between events, so latency offsets cancel
`timescale 1ns/100ps
module test_rmw_bus_cycle_and_arbitration
  import rmw_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              arst_n, start, halt_in_n, bus_request_n, grant_ack_n;
  logic              transfer_ack_n, bus_error_n, data_oe, address_oe, ctrl_oe;
  logic              addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, data_strobe_n;
  logic              read_write_n, early_read_write_n, cycle_start_indicator, locked_cycle_n;
  logic              bus_grant_n, done, bus_fault;
  logic [ADDR_W-1:0] addr_in, address;
  logic [FC_W-1:0]   fc_in, function_code;
  logic [7:0]        modify_mask, read_byte;
  logic [DATA_W-1:0] data_in, data_out, rd_data;
  logic [1:0]        rd_mode, wr_mode;
  logic [3:0]        wait_cyc;
  int                num_errors = 0;
  int                comparisons = 0;

  always #20 clk_sys = ~clk_sys;
  rmw_sequencer dut_u (.*);
  rmw_slave_model slave_u (.*);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic reset_test();
    repeat (2) @(posedge clk_sys);
    check({addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, data_strobe_n, read_write_n,
           early_read_write_n, locked_cycle_n, bus_grant_n, data_oe, done}, 10'h3fc);
    arst_n <= 1'b1;
  endtask

  task automatic run_cycle(input logic [31:0] a, input logic [7:0] m, input logic [15:0] rd,
                           input int rm, input int wm, input int w);
    int         c, rises = 0, bad = 0, as_lo = -1, as_hi = -1, ds_hi = -1;
    int         ds_last = -1, ds2 = -1, erw = -1, rw = -1, oe = -1;
    logic       p_as, p_ds, p_erw, p_rw, p_oe;
    logic [7:0] wr, exp_b;
    exp_b = a[0] ? rd[7:0] : rd[15:8];
    @(posedge clk_sys);
    start <= 1'b1;
    addr_in <= a;
    fc_in <= 3'h5;
    modify_mask <= m;
    rd_data <= rd;
    rd_mode <= rm[1:0];
    wr_mode <= wm[1:0];
    wait_cyc <= w[3:0];
    halt_in_n <= (rm == 2 || wm == 2) ? 1'b0 : 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    {p_as, p_ds, p_erw, p_rw, p_oe} = 5'h1e;
    for (c = 0; c < 200 && done !== 1'b1; c++) begin
      @(negedge clk_sys);
      if (!data_strobe_n && {upper_byte_strobe_n, lower_byte_strobe_n} !== {a[0], ~a[0]}) bad++;
      if (!addr_strobe_n && p_as) begin
        as_lo = c;
        if (address !== a || function_code !== 3'h5) bad++;
        if ({read_write_n, early_read_write_n, cycle_start_indicator, locked_cycle_n} !== 4'hc) bad++;
      end
      if (addr_strobe_n && !p_as) begin
        as_hi = c;
        rises++;
      end
      if (data_strobe_n && !p_ds) begin
        if (ds_hi < 0) ds_hi = c;
        ds_last = c;
      end
      if (!data_strobe_n && p_ds && c != as_lo) ds2 = c;
      if (!early_read_write_n && p_erw) erw = c;
      if (!read_write_n && p_rw) rw = c;
      if (data_oe && !p_oe) begin
        oe = c;
        wr = a[0] ? data_out[7:0] : data_out[15:8];
      end
      {p_as, p_ds, p_erw, p_rw, p_oe} = {addr_strobe_n, data_strobe_n, early_read_write_n, read_write_n, data_oe};
    end
    check(c < 200, 1'b1);
    check(rises, 1);
    check(bad, 0);
    check(ds_hi - as_lo, 2 + w + (rm == 2 ? 2 : 0));
    check(as_hi - ds_last, rm == 1 ? 4 : rm == 2 ? 2 : 0);
    check(rw >= 0, rm == 0);
    if (rm == 0) begin
      check(read_byte, exp_b);
      check(wr, exp_b | m);
      check(erw - ds_hi, 5);
      check(rw - erw, 1);
      check(oe - rw, 1);
      check(ds2 - oe, 1);
      check(as_hi - ds2, 2 + w + (wm == 2 ? 3 : 0));
    end
    @(negedge clk_sys);
    check(bus_fault, rm != 0 || wm != 0);
    if (rm == 0 && wm == 0) check(locked_cycle_n, 1'b1);
    check(cycle_start_indicator, 1'b1);
  endtask

  task automatic arb_test();
    int c;
    @(posedge clk_sys);
    rd_mode <= 2'h0;
    wr_mode <= 2'h0;
    // External master asks for the bus
    bus_request_n <= 1'b0;
    for (c = 0; c < 10 && bus_grant_n !== 1'b0; c++) @(negedge clk_sys);
    check(c < 10, 1'b1);
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check({addr_strobe_n, address_oe, ctrl_oe, data_oe}, 4'h8);
    // Bus taken with the strobe idle; request kept for a regrant
    @(posedge clk_sys);
    grant_ack_n <= 1'b0;
    for (c = 0; c < 10 && bus_grant_n !== 1'b1; c++) @(negedge clk_sys);
    check(c >= 3 && c <= 4, 1'b1);
    for (c = 0; c < 10 && bus_grant_n !== 1'b0; c++) @(negedge clk_sys);
    check(c < 10 && addr_strobe_n === 1'b1, 1'b1);
    @(posedge clk_sys);
    bus_request_n <= 1'b1;
    grant_ack_n <= 1'b1;
    for (c = 0; c < 10 && bus_grant_n !== 1'b1; c++) @(negedge clk_sys);
    check(c < 10, 1'b1);
    // Request synced while the cycle sits committed, once arbiter is idle again
    repeat (4) @(posedge clk_sys);
    bus_request_n <= 1'b0;
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    for (c = 0; c < 20 && bus_grant_n !== 1'b0; c++) @(negedge clk_sys);
    check({c < 20, addr_strobe_n}, 2'b10);
    for (c = 0; c < 100 && done !== 1'b1; c++) @(negedge clk_sys);
    check(c < 100, 1'b1);
    @(posedge clk_sys);
    bus_request_n <= 1'b1;
    for (c = 0; c < 10 && bus_grant_n !== 1'b1; c++) @(negedge clk_sys);
    check(c < 10, 1'b1);
  endtask

  // Whole run is near 200 clocks; a hang is cut well beyond that
  initial begin
    #(CLK_NS * 5000);
    num_errors++;
    wrap_up();
  end

  initial begin
    {arst_n, start, halt_in_n, bus_request_n, grant_ack_n} = 5'h07;
    addr_in = '0;
    fc_in = '0;
    modify_mask = '0;
    rd_data = '0;
    {rd_mode, wr_mode, wait_cyc} = '0;
    reset_test();
    run_cycle(32'h0000_1000, 8'h80, 16'h3c5a, 0, 0, 0);
    run_cycle(32'h0000_2001, 8'h01, 16'ha5c3, 0, 0, 3);
    run_cycle(32'h0000_3000, 8'h0f, 16'h1234, 1, 0, 1);
    run_cycle(32'h0000_3001, 8'h0f, 16'h1234, 2, 0, 0);
    run_cycle(32'h0000_4000, 8'hf0, 16'h00ff, 0, 2, 2);
    run_cycle(32'h0000_4001, 8'h55, 16'hff00, 0, 1, 0);
    arb_test();
    run_cycle(32'hffff_fffe, 8'h00, 16'h8001, 0, 0, 0);
    wrap_up();
  end
endmodule
